//--- merc_ctrl.sv
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
// Behaviour
// - memory single-bit correction runs only while memory command bit 2 is set.
// - quadword-half identification of single-bit errors works only with correction on.
// - memory command bit 1 logs correctable memory errors and pulses sideband error.
// - memory command bit 0 logs uncorrectable errors; bus error if its driver on.
// - memory status bits clear on write-one, write-zero keeps, reset to zero.
// - memory status bit 1 correctable, bit 0 uncorrectable, upper bits reserved.
// - all ECC check bits written are zero while system command bits 9..7 clear.
// - host variant: system command bit 9 enables host data correction.
// - host variant: bit 8 logs host correctable errors and pulses sideband error.
// - host variant: bit 7 lets host uncorrectable errors drive bus error if enabled; logging is unconditional.
// - memory-only variant: bit 7 turns memory ECC on; array initialised first.
// - system command bit 5 enables driving address-error on request parity errors.
// - system command bit 4 loaded at reset from host address line 8.
// - system command bit 3 enables driving bus-error for uncorrectable errors.
// - system command bit 2 loaded at reset from host address line 9.
// - system command bit 1 enables bus-initialise on protocol violations.
// - system command bit 0 loaded at reset from host address line 10.
// - system command resets with straps in bits 4,2,0; others zero.
// - host variant: host uncorrectable flag sets on multi-bit error regardless.
// - host variant: host single-bit error logged in bit 2 while bit 8 set, sideband error pulsed.
module merc_ctrl #(
	parameter bit HOST_ECC = 1'b1,
	parameter int STRAP_CYCLES = 4
) (
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire merc_pkg::merc_reg_req_s reg_req_i,
	output logic [15:0] reg_rdata_o,
	input wire merc_pkg::merc_events_s events_i,
	input wire logic host_address_line_8_i,
	input wire logic host_address_line_9_i,
	input wire logic host_address_line_10_i,
	input wire logic [7:0] ecc_check_in_i,
	output logic [7:0] ecc_check_out_o,
	output logic mem_correct_en_o,
	output logic host_correct_en_o,
	output logic half_identify_en_o,
	output logic mem_ecc_en_o,
	output logic sideband_correctable_error_n_o,
	output logic bus_error_n_o,
	output logic address_error_n_o,
	output logic bus_initialise_n_o,
	output logic address_error_n_in_en_o,
	output logic bus_error_n_in_en_o,
	output logic bus_initialise_n_in_en_o
);
	import merc_pkg::*;

	// the third stage is full only after the third edge, so four is the least
	if (STRAP_CYCLES < 4 || STRAP_CYCLES > 255) begin : g_bad_strap
		$error("merc_ctrl: STRAP_CYCLES out of range");
	end

	localparam logic [15:0] SC_MASK = HOST_ECC ? MERC_SC_MASK_HOST :
		MERC_SC_MASK_MEM;
	localparam logic [15:0] SS_MASK = HOST_ECC ? MERC_SS_MASK_HOST :
		MERC_SS_MASK_MEM;

	logic [15:0] mem_cmd_ff;
	logic [15:0] mem_sts_ff;
	logic [15:0] sys_cmd_ff;
	logic [15:0] sys_sts_ff;
	logic [15:0] nxt_mem_sts;
	logic [15:0] nxt_sys_sts;
	logic [15:0] mem_set;
	logic [15:0] sys_set;
	logic [15:0] mem_clr;
	logic [15:0] sys_clr;

	// strap pins are async to mclk: three stages, vote on the last two
	logic [2:0] s8_ff;
	logic [2:0] s9_ff;
	logic [2:0] s10_ff;
	logic [7:0] strap_cnt_ff;
	logic strap_done_ff;

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s8_ff <= 3'h0;
			s9_ff <= 3'h0;
			s10_ff <= 3'h0;
		end else begin
			s8_ff <= {s8_ff[1:0], host_address_line_8_i};
			s9_ff <= {s9_ff[1:0], host_address_line_9_i};
			s10_ff <= {s10_ff[1:0], host_address_line_10_i};
		end
	end

	// straps are taken once, a few cycles after release, when the chain is full
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			strap_cnt_ff <= 8'h00;
			strap_done_ff <= 1'b0;
		end else if (!strap_done_ff) begin
			strap_cnt_ff <= strap_cnt_ff + 8'h01;
			if (strap_cnt_ff == 8'(STRAP_CYCLES - 1)) begin
				strap_done_ff <= 1'b1;
			end
		end
	end

	wire strap_take = !strap_done_ff &&
		(strap_cnt_ff == 8'(STRAP_CYCLES - 1));
	wire wr_mc = reg_req_i.wr && reg_req_i.addr == MERC_OFS_MEM_CMD;
	wire wr_ms = reg_req_i.wr && reg_req_i.addr == MERC_OFS_MEM_STS;
	wire wr_sc = reg_req_i.wr && reg_req_i.addr == MERC_OFS_SYS_CMD;
	wire wr_ss = reg_req_i.wr && reg_req_i.addr == MERC_OFS_SYS_STS;

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mem_cmd_ff <= MERC_MC_RESET;
		end else if (wr_mc) begin
			mem_cmd_ff <= reg_req_i.wdata & MERC_MC_MASK;
		end
	end

	// straps (agreeing last two stages) load the input-enable bits
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sys_cmd_ff <= MERC_SC_RESET;
		end else if (strap_take) begin
			sys_cmd_ff[MERC_SC_ADDRESS_ERROR_N_IN] <= s8_ff[2] & s8_ff[1];
			sys_cmd_ff[MERC_SC_BUS_ERROR_N_IN] <= s9_ff[2] & s9_ff[1];
			sys_cmd_ff[MERC_SC_BUS_INITIALISE_N_IN] <= s10_ff[2] & s10_ff[1];
		end else if (wr_sc) begin
			sys_cmd_ff <= reg_req_i.wdata & SC_MASK;
		end
	end

	always_comb begin
		mem_set = 16'h0000;
		sys_set = 16'h0000;
		mem_set[MERC_MS_CE] = events_i.mem_single &&
			mem_cmd_ff[MERC_MC_REP_CE];
		mem_set[MERC_MS_UE] = events_i.mem_multi &&
			mem_cmd_ff[MERC_MC_REP_UE];
		sys_set[MERC_SS_HOST_CE] = events_i.host_single &&
			sys_cmd_ff[MERC_SC_HOST_CE];
		sys_set[MERC_SS_HOST_UE] = events_i.host_multi;
		sys_set[MERC_SS_RPAR] = events_i.req_parity;
		sys_set[MERC_SS_APAR] = events_i.addr_parity;
		sys_set[MERC_SS_PROTO] = events_i.protocol;
		mem_clr = wr_ms ? reg_req_i.wdata : 16'h0000;
		sys_clr = wr_ss ? reg_req_i.wdata : 16'h0000;
		// set wins over a simultaneous clear
		nxt_mem_sts = ((mem_sts_ff & ~mem_clr) | mem_set) &
			MERC_MS_MASK;
		nxt_sys_sts = ((sys_sts_ff & ~sys_clr) | sys_set) & SS_MASK;
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mem_sts_ff <= MERC_MS_RESET;
			sys_sts_ff <= MERC_SS_RESET;
		end else begin
			mem_sts_ff <= nxt_mem_sts;
			sys_sts_ff <= nxt_sys_sts;
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			reg_rdata_o <= 16'h0000;
		end else if (reg_req_i.rd) begin
			case (reg_req_i.addr)
				MERC_OFS_MEM_CMD: reg_rdata_o <= mem_cmd_ff;
				MERC_OFS_MEM_STS: reg_rdata_o <= mem_sts_ff;
				MERC_OFS_SYS_CMD: reg_rdata_o <= sys_cmd_ff;
				MERC_OFS_SYS_STS: reg_rdata_o <= sys_sts_ff;
				default: reg_rdata_o <= 16'h0000;
			endcase
		end else begin
			reg_rdata_o <= 16'h0000;
		end
	end

	// check bits are forced to zero for error injection when 9..7 all clear
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ecc_check_out_o <= 8'h00;
		end else if (sys_cmd_ff[MERC_SC_HOST_CORR:MERC_SC_HOST_UE] == 3'h0) begin
			ecc_check_out_o <= 8'h00;
		end else begin
			ecc_check_out_o <= ecc_check_in_i;
		end
	end

	// enables, registered from the command registers
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mem_correct_en_o <= 1'b0;
			half_identify_en_o <= 1'b0;
			host_correct_en_o <= 1'b0;
			mem_ecc_en_o <= 1'b0;
			address_error_n_in_en_o <= 1'b0;
			bus_error_n_in_en_o <= 1'b0;
			bus_initialise_n_in_en_o <= 1'b0;
		end else begin
			mem_correct_en_o <= mem_cmd_ff[MERC_MC_CORR_EN];
			half_identify_en_o <= mem_cmd_ff[MERC_MC_CORR_EN];
			host_correct_en_o <= HOST_ECC &&
				sys_cmd_ff[MERC_SC_HOST_CORR];
			// memory-only variant: bit 7 is the array ECC switch
			mem_ecc_en_o <= HOST_ECC || sys_cmd_ff[MERC_SC_HOST_UE];
			address_error_n_in_en_o <= sys_cmd_ff[MERC_SC_ADDRESS_ERROR_N_IN];
			bus_error_n_in_en_o <= sys_cmd_ff[MERC_SC_BUS_ERROR_N_IN];
			bus_initialise_n_in_en_o <= sys_cmd_ff[MERC_SC_BUS_INITIALISE_N_IN];
		end
	end

	// error signals on the host bus: active low, one cycle per event
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sideband_correctable_error_n_o <= 1'b1;
			bus_error_n_o <= 1'b1;
			address_error_n_o <= 1'b1;
			bus_initialise_n_o <= 1'b1;
		end else begin
			sideband_correctable_error_n_o <= !(
				(events_i.mem_single && mem_cmd_ff[MERC_MC_REP_CE]) ||
				(HOST_ECC && events_i.host_single &&
				sys_cmd_ff[MERC_SC_HOST_CE]));
			bus_error_n_o <= !(sys_cmd_ff[MERC_SC_BUS_ERROR_N_DRV] && (
				(events_i.mem_multi && mem_cmd_ff[MERC_MC_REP_UE]) ||
				(HOST_ECC && events_i.host_multi &&
				sys_cmd_ff[MERC_SC_HOST_UE])));
			address_error_n_o <= !(sys_cmd_ff[MERC_SC_ADDRESS_ERROR_N_DRV] &&
				events_i.req_parity);
			bus_initialise_n_o <= !(sys_cmd_ff[MERC_SC_BUS_INITIALISE_N_DRV] &&
				events_i.protocol);
		end
	end
endmodule

//--- merc_pkg.sv
package merc_pkg;
	// register byte offsets (16-bit registers, each at its own offset)
	localparam logic [7:0] MERC_OFS_MEM_CMD = 8'hC0;
	localparam logic [7:0] MERC_OFS_MEM_STS = 8'hC2;
	localparam logic [7:0] MERC_OFS_SYS_CMD = 8'hC4;
	localparam logic [7:0] MERC_OFS_SYS_STS = 8'hC6;

	// memory error command fields
	localparam int MERC_MC_CORR_EN = 2;
	localparam int MERC_MC_REP_CE = 1;
	localparam int MERC_MC_REP_UE = 0;
	localparam logic [15:0] MERC_MC_MASK = 16'h0007;
	localparam logic [15:0] MERC_MC_RESET = 16'h0000;

	// memory error status fields
	localparam int MERC_MS_CE = 1;
	localparam int MERC_MS_UE = 0;
	localparam logic [15:0] MERC_MS_MASK = 16'h0003;
	localparam logic [15:0] MERC_MS_RESET = 16'h0000;

	// system error command fields
	localparam int MERC_SC_HOST_CORR = 9;
	localparam int MERC_SC_HOST_CE = 8;
	localparam int MERC_SC_HOST_UE = 7;
	localparam int MERC_SC_ADDRESS_ERROR_N_DRV = 5;
	localparam int MERC_SC_ADDRESS_ERROR_N_IN = 4;
	localparam int MERC_SC_BUS_ERROR_N_DRV = 3;
	localparam int MERC_SC_BUS_ERROR_N_IN = 2;
	localparam int MERC_SC_BUS_INITIALISE_N_DRV = 1;
	localparam int MERC_SC_BUS_INITIALISE_N_IN = 0;
	localparam logic [15:0] MERC_SC_MASK_HOST = 16'h03BF;
	localparam logic [15:0] MERC_SC_MASK_MEM = 16'h00BF;
	localparam logic [15:0] MERC_SC_RESET = 16'h0000;

	// system error status fields
	localparam int MERC_SS_APAR = 4;
	localparam int MERC_SS_RPAR = 3;
	localparam int MERC_SS_HOST_CE = 2;
	localparam int MERC_SS_HOST_UE = 1;
	localparam int MERC_SS_PROTO = 0;
	localparam logic [15:0] MERC_SS_MASK_HOST = 16'h001F;
	localparam logic [15:0] MERC_SS_MASK_MEM = 16'h0019;
	localparam logic [15:0] MERC_SS_RESET = 16'h0000;

	localparam logic [1:0] MERC_SYNC_RESET = 2'h0;

	// error events from the datapath, each a one-cycle pulse
	typedef struct packed {
		logic mem_single; // single-bit error seen on memory read data
		logic mem_multi; // multi-bit error seen on memory read data
		logic host_single; // single-bit error on host bus data
		logic host_multi; // multi-bit error on host bus data
		logic req_parity; // request parity error
		logic addr_parity; // address parity error
		logic protocol; // host bus protocol violation
	} merc_events_s;

	// register access port
	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} merc_reg_req_s;
endpackage

//--- merc_checker.sv
`timescale 1ns/1ps
module merc_checker (
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire merc_pkg::merc_reg_req_s reg_req_i,
	input wire merc_pkg::merc_events_s events_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic [7:0] ecc_check_out_o,
	input wire logic mem_correct_en_o,
	input wire logic half_identify_en_o,
	input wire logic sideband_correctable_error_n_o,
	input wire logic bus_error_n_o,
	input wire logic address_error_n_o,
	input wire logic bus_initialise_n_o
);
	import merc_pkg::*;
	// command shadows rebuilt from writes; strap bits are never used here
	logic [2:0] mc_ff;
	logic [9:0] sc_ff;
	logic ce;
	logic ue;
	assign ce = events_i.mem_single & mc_ff[1] | events_i.host_single & sc_ff[8];
	assign ue = sc_ff[3] & (events_i.mem_multi & mc_ff[0]
		| events_i.host_multi & sc_ff[7]);
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mc_ff <= 3'h0;
			sc_ff <= 10'h000;
		end else if (reg_req_i.wr) begin
			case (reg_req_i.addr)
			MERC_OFS_MEM_CMD: mc_ff <= reg_req_i.wdata[2:0];
			MERC_OFS_SYS_CMD: sc_ff <= reg_req_i.wdata[9:0];
			default: ;
			endcase
		end
	end
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);
	sequence s_ce; ce; endsequence
	sequence s_ue; ue; endsequence
	property p_ce; s_ce |=> !sideband_correctable_error_n_o; endproperty
	property p_ce_off; !ce |=> sideband_correctable_error_n_o; endproperty
	property p_ue; s_ue |=> !bus_error_n_o; endproperty
	property p_ue_off; !ue |=> bus_error_n_o; endproperty
	property p_address_error_n; events_i.req_parity && sc_ff[5] |=> !address_error_n_o;
	endproperty
	property p_address_error_n_off; !sc_ff[5] |=> address_error_n_o; endproperty
	property p_bus_initialise_n; events_i.protocol && sc_ff[1] |=> !bus_initialise_n_o;
	endproperty
	property p_bus_initialise_n_off; !sc_ff[1] |=> bus_initialise_n_o; endproperty
	property p_ecc; sc_ff[9:7] == 3'h0 |=> ecc_check_out_o == 8'h00; endproperty
	property p_corr; $stable(mc_ff[2]) [*3] |-> mem_correct_en_o == mc_ff[2];
	endproperty
	property p_half; half_identify_en_o == mem_correct_en_o; endproperty
	property p_idle; !reg_req_i.rd |=> reg_rdata_o == 16'h0000; endproperty
	a_ce: assert property (p_ce) else $error("sideband missing");
	a_ce_off: assert property (p_ce_off) else $error("stray sideband");
	a_ue: assert property (p_ue) else $error("bus error missing");
	a_ue_off: assert property (p_ue_off) else $error("stray bus error");
	a_address_error_n: assert property (p_address_error_n) else $error("addr error missing");
	a_address_error_n_off: assert property (p_address_error_n_off) else $error("stray address_error_n");
	a_bus_initialise_n: assert property (p_bus_initialise_n) else $error("bus_initialise_n missing");
	a_bus_initialise_n_off: assert property (p_bus_initialise_n_off) else $error("stray bus_initialise_n");
	a_ecc: assert property (p_ecc) else $error("check bits not zero");
	a_corr: assert property (p_corr) else $error("correction enable");
	a_half: assert property (p_half) else $error("half identify");
	a_idle: assert property (p_idle) else $error("read data not zero");
endmodule

//--- merc_host_agent.sv
`timescale 1ns/1ps
module merc_host_agent #(
	parameter logic [2:0] STRAPS = 3'h5
) (
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire merc_pkg::merc_events_s fire_i,
	output merc_pkg::merc_events_s events_o,
	output logic line8_o,
	output logic line9_o,
	output logic line10_o
);
	import merc_pkg::*;
	// straps are held for the whole run, as a board would hold them
	assign line8_o = STRAPS[0];
	assign line9_o = STRAPS[1];
	assign line10_o = STRAPS[2];
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			events_o <= '0;
		end else begin
			events_o <= fire_i;
		end
	end
endmodule

//--- memory_error_report_control_test.sv
`timescale 1ns/1ps
module memory_error_report_control_test;
	import merc_pkg::*;
	logic mclk_i = 1'b0;
	logic arst_n_i = 1'b0;
	merc_reg_req_s reg_req_i = '0;
	merc_events_s fire = '0;
	merc_events_s events_i;
	wire host_address_line_8_i, host_address_line_9_i, host_address_line_10_i;
	logic [7:0] ecc_check_in_i = 8'h5A;
	logic [15:0] reg_rdata_o;
	logic [7:0] ecc_check_out_o;
	logic mem_correct_en_o, host_correct_en_o, half_identify_en_o;
	logic mem_ecc_en_o, sideband_correctable_error_n_o, bus_error_n_o;
	logic address_error_n_o, bus_initialise_n_o;
	logic address_error_n_in_en_o, bus_error_n_in_en_o, bus_initialise_n_in_en_o;
	int error_cnt = 0;
	int num_checks = 0;
	int cyc = 0;
	always #2.5 mclk_i = ~mclk_i;
	merc_host_agent #(.STRAPS(3'h5)) agent (.mclk_i, .arst_n_i, .fire_i(fire),
		.events_o(events_i), .line8_o(host_address_line_8_i),
		.line9_o(host_address_line_9_i), .line10_o(host_address_line_10_i));
	merc_ctrl #(.HOST_ECC(1'b1), .STRAP_CYCLES(4)) dut (.mclk_i(mclk_i),
		.arst_n_i(arst_n_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
		.events_i(events_i), .host_address_line_8_i(host_address_line_8_i),
		.host_address_line_9_i(host_address_line_9_i),
		.host_address_line_10_i(host_address_line_10_i),
		.ecc_check_in_i(ecc_check_in_i), .ecc_check_out_o(ecc_check_out_o),
		.mem_correct_en_o(mem_correct_en_o),
		.host_correct_en_o(host_correct_en_o),
		.half_identify_en_o(half_identify_en_o), .mem_ecc_en_o(mem_ecc_en_o),
		.sideband_correctable_error_n_o(sideband_correctable_error_n_o),
		.bus_error_n_o(bus_error_n_o), .address_error_n_o(address_error_n_o),
		.bus_initialise_n_o(bus_initialise_n_o), .address_error_n_in_en_o(address_error_n_in_en_o),
		.bus_error_n_in_en_o(bus_error_n_in_en_o), .bus_initialise_n_in_en_o(bus_initialise_n_in_en_o));
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(string n, logic [15:0] seen, logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [15:0] d);
		@(posedge mclk_i);
		reg_req_i <= '{a, d, 1'b1, 1'b0};
		@(posedge mclk_i);
		reg_req_i <= '0;
	endtask
	task automatic rd(logic [7:0] a, logic [15:0] exp);
		@(posedge mclk_i);
		reg_req_i <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge mclk_i);
		reg_req_i <= '0;
		#1 chk($sformatf("reg %h", a), reg_rdata_o, exp);
	endtask
	// exp_n: sideband, bus error, address error, bus initialise (1 = idle)
	task automatic fire_ev(merc_events_s e, logic [3:0] exp_n);
		@(posedge mclk_i);
		fire <= e;
		@(posedge mclk_i);
		fire <= '0;
		@(posedge mclk_i);
		#1 chk("err_n", {12'h000, sideband_correctable_error_n_o,
			bus_error_n_o, address_error_n_o, bus_initialise_n_o},
			{12'h000, exp_n});
		@(posedge mclk_i);
	endtask
	// generous ceiling: the sequence needs well under a thousand cycles
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			conclude();
		end
	end
	initial begin
		repeat (12) @(posedge mclk_i);
		arst_n_i <= 1'b1;
		repeat (5) @(posedge mclk_i);
		rd(MERC_OFS_SYS_CMD, 16'h0011);
		chk("in_en", {12'h000, address_error_n_in_en_o, bus_error_n_in_en_o, bus_initialise_n_in_en_o,
			mem_ecc_en_o}, 16'h000B);
		rd(MERC_OFS_MEM_CMD, 16'h0000);
		rd(MERC_OFS_MEM_STS, 16'h0000);
		$display("test reset done");
		wr(MERC_OFS_MEM_CMD, 16'hFFFF);
		rd(MERC_OFS_MEM_CMD, 16'h0007);
		chk("corr", {14'h0000, mem_correct_en_o, half_identify_en_o},
			16'h0003);
		wr(MERC_OFS_SYS_CMD, 16'hFFFF);
		rd(MERC_OFS_SYS_CMD, 16'h03BF);
		chk("host_corr", {15'h0000, host_correct_en_o}, 16'h0001);
		wr(8'hC8, 16'hFFFF);
		rd(8'hC8, 16'h0000);
		// each of bits 9..7 alone must let the check bits through
		for (int b = 7; b < 10; b++) begin
			wr(MERC_OFS_SYS_CMD, 16'h0001 << b);
			rd(MERC_OFS_SYS_CMD, 16'h0001 << b);
			chk("ecc", {8'h00, ecc_check_out_o}, 16'h005A);
		end
		wr(MERC_OFS_SYS_CMD, 16'h002A);
		rd(MERC_OFS_SYS_CMD, 16'h002A);
		chk("ecc", {8'h00, ecc_check_out_o}, 16'h0000);
		$display("test command done");
		wr(MERC_OFS_SYS_CMD, 16'h03AA);
		fire_ev(7'h40, 4'h7);
		rd(MERC_OFS_MEM_STS, 16'h0002);
		fire_ev(7'h20, 4'hB);
		rd(MERC_OFS_MEM_STS, 16'h0003);
		wr(MERC_OFS_MEM_STS, 16'h0000);
		rd(MERC_OFS_MEM_STS, 16'h0003);
		wr(MERC_OFS_MEM_STS, 16'hFFFD);
		rd(MERC_OFS_MEM_STS, 16'h0002);
		wr(MERC_OFS_MEM_STS, 16'h0002);
		rd(MERC_OFS_MEM_STS, 16'h0000);
		fire_ev(7'h1D, 4'h0);
		rd(MERC_OFS_SYS_STS, 16'h000F);
		wr(MERC_OFS_SYS_STS, 16'h001F);
		$display("test logging done");
		wr(MERC_OFS_MEM_CMD, 16'h0004);
		wr(MERC_OFS_SYS_CMD, 16'h0000);
		fire_ev(7'h7F, 4'hF);
		rd(MERC_OFS_MEM_STS, 16'h0000);
		rd(MERC_OFS_SYS_STS, 16'h001B);
		$display("test disabled done");
		wr(MERC_OFS_MEM_CMD, 16'h0001);
		@(posedge mclk_i);
		fire <= 7'h20;
		@(posedge mclk_i);
		fire <= '0;
		reg_req_i <= '{MERC_OFS_MEM_STS, 16'h0003, 1'b1, 1'b0};
		@(posedge mclk_i);
		reg_req_i <= '0;
		rd(MERC_OFS_MEM_STS, 16'h0001);
		$display("test set over clear done");
		conclude();
	end
endmodule
bind merc_ctrl merc_checker chk_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
	.reg_req_i(reg_req_i), .events_i(events_i), .reg_rdata_o(reg_rdata_o),
	.ecc_check_out_o(ecc_check_out_o), .mem_correct_en_o(mem_correct_en_o),
	.half_identify_en_o(half_identify_en_o),
	.sideband_correctable_error_n_o(sideband_correctable_error_n_o),
	.bus_error_n_o(bus_error_n_o), .address_error_n_o(address_error_n_o),
	.bus_initialise_n_o(bus_initialise_n_o));
